// *** hw/tmr_top.sv ***
`timescale 1ns/1ps
`include "tmr_map.svh"

// Overview of operation
// (R01) free-running: pin A selected edge copies count to capture_compare_b, pulses capture_b_irq
// (R02) pin B selected edge copies count to capture_compare_a, pulses match_a_irq
// (R03) software selects both edges on both pins for two pulse widths
// (R04) captures follow two equal samples taken on the count clock
// (R05) two-register: opposite pin A edge captures count into capture_compare_a
// (R06) restart: pin A edge captures into capture_compare_b, then clears counter
// (R07) software selects exactly one pin A edge polarity in restart mode
// (R08) software clears overflow_flag itself after checking it
// (R09) event counter increments once per valid pin A edge
// (R10) event counter clears on count equal capture_compare_a, pulses match_a_irq
// (R11) software loads nonzero capture_compare_a for event counting
// (R12) event edge selection allows rising, falling or both edges
// (R13) event mode samples pin A on the system clock, twice
// (R14) event mode overflows only when capture_compare_a holds all ones
// (R15) software reads the count register for the event total
// (R16) output enable plus toggle inverts pin every capture_compare_a plus one counts
// (R17) software leaves capture_compare_a alone while square wave runs
// (R18) software sets clock, capture control, output control, compare, then mode
// (R19) one-shot pulse started by software trigger or pin A edge
// (R20) software loads nonzero compare values before one-shot start
// (R21) count clock select bits pick the counter increment clock
// (R22) software changes pin A edge select only while stopped
// (R23) counter runs whenever operating mode is not stop
// (R24) wrap from all ones sets overflow_flag; early clear is overridden
// (R25) free-running counter wraps through full range, untouched by captures
module tmr_top (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   output tmr_pkg::tmr_resp_t       s_axi_bresp,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   input  wire logic [7:0]          s_axi_araddr,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output logic [31:0]              s_axi_rdata,
   output tmr_pkg::tmr_resp_t       s_axi_rresp,
   input  wire logic                input_pin_a,
   input  wire logic                input_pin_b,
   output logic                     timer_output_pin,
   output logic                     match_a_irq,
   output logic                     capture_b_irq
);
   import tmr_pkg::*;

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      return (a[1:0] == 2'b00) && (a <= `TMR_STATUS_OFS);
   endfunction

   // bus state
   logic              aw_hold_q;
   logic [7:0]        aw_addr_q;
   logic              w_hold_q;
   logic [31:0]       w_data_q;
   logic [3:0]        w_strb_q;
   // registers
   logic [7:0]        mode_control_reg_q;
   logic [7:0]        capture_compare_ctrl_reg_q;
   logic [7:0]        prescaler_mode_reg_q;
   logic [7:0]        output_control_reg_q;
   logic [15:0]       capture_compare_a_q;
   logic [15:0]       capture_compare_b_q;
   logic [15:0]       count_register_q;
   logic              overflow_flag_q;
   logic              ovf_hold_q;
   tmr_os_t           os_q;
   logic              out_q;

   // bus decode
   logic              aw_take;
   logic              w_take;
   logic              ar_take;
   logic              wr_do;
   logic              wr_ok;
   logic [31:0]       wr_val;
   logic [31:0]       rd_val;
   logic              wr_mode;
   logic              wr_ccctrl;
   logic              wr_presc;
   logic              wr_outctrl;
   logic              wr_cca;
   logic              wr_ccb;
   logic              wr_status;

   assign aw_take  = s_axi_awvalid & s_axi_awready;
   assign w_take   = s_axi_wvalid & s_axi_wready;
   assign ar_take  = s_axi_arvalid & s_axi_arready;
   assign wr_do    = aw_hold_q & w_hold_q & ~s_axi_bvalid;
   assign wr_ok    = mapped(aw_addr_q);
   assign wr_val   = merge(32'h0000_0000, w_data_q, w_strb_q);
   assign wr_mode    = wr_do & (aw_addr_q == `TMR_MODE_CTRL_OFS) & w_strb_q[0];
   assign wr_ccctrl  = wr_do & (aw_addr_q == `TMR_CC_CTRL_OFS) & w_strb_q[0];
   assign wr_presc   = wr_do & (aw_addr_q == `TMR_PRESCALER_OFS) & w_strb_q[0];
   assign wr_outctrl = wr_do & (aw_addr_q == `TMR_OUT_CTRL_OFS) & w_strb_q[0];
   assign wr_cca     = wr_do & (aw_addr_q == `TMR_CC_A_OFS);
   assign wr_ccb     = wr_do & (aw_addr_q == `TMR_CC_B_OFS);
   assign wr_status  = wr_do & (aw_addr_q == `TMR_STATUS_OFS) & w_strb_q[0];

   // field views
   tmr_mode_t         opmode;
   logic [1:0]        clk_sel;
   logic [1:0]        edge_a_sel;
   logic [1:0]        edge_b_sel;
   logic              cca_capture;
   logic              cca_src_a;
   logic              ccb_capture;
   logic              out_en;
   logic              toggle_a;
   logic              os_en;
   logic              os_ext;
   logic              run;
   logic              event_mode;

   assign opmode      = tmr_mode_t'(mode_control_reg_q[`TMR_OPMODE_LSB +: 2]);
   assign clk_sel     = prescaler_mode_reg_q[`TMR_CLKSEL_LSB +: 2];
   assign edge_a_sel  = prescaler_mode_reg_q[`TMR_EDGE_A_LSB +: 2];
   assign edge_b_sel  = prescaler_mode_reg_q[`TMR_EDGE_B_LSB +: 2];
   assign cca_capture = capture_compare_ctrl_reg_q[`TMR_CCA_CAPTURE_BIT];
   assign cca_src_a   = capture_compare_ctrl_reg_q[`TMR_CCA_SRC_A_BIT];
   assign ccb_capture = capture_compare_ctrl_reg_q[`TMR_CCB_CAPTURE_BIT];
   assign out_en      = output_control_reg_q[`TMR_OUT_EN_BIT];
   assign toggle_a    = output_control_reg_q[`TMR_TOGGLE_A_BIT];
   assign os_en       = output_control_reg_q[`TMR_ONESHOT_BIT];
   assign os_ext      = output_control_reg_q[`TMR_OS_EXT_BIT];
   // (R23) any mode but stop runs the counter
   assign run         = (opmode != MODE_STOP);
   assign event_mode  = (clk_sel == `TMR_CLK_PIN_A);

   // count clock and pin filters
   logic              tick;
   logic              a_sample;
   logic              a_edge_raw;
   logic              a_opp_raw;
   logic              b_edge_raw;
   logic              a_edge;
   logic              a_opp;
   logic              b_edge;

   // (R13) event mode filters pin A on the system clock
   assign a_sample = event_mode ? 1'b1 : tick;

   // (R04) filter sampled on the count clock
   tmr_edge_filter u_filt_a (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .sample     (a_sample),
      .pin        (input_pin_a),
      .edge_sel   (edge_a_sel),
      .valid_edge (a_edge_raw),
      .opp_edge   (a_opp_raw)
   );

   tmr_edge_filter u_filt_b (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .sample     (a_sample),
      .pin        (input_pin_b),
      .edge_sel   (edge_b_sel),
      .valid_edge (b_edge_raw),
      .opp_edge   ()
   );

   assign a_edge = run & a_edge_raw;
   assign a_opp  = run & a_opp_raw;
   assign b_edge = run & b_edge_raw;

   // (R09) (R12) pin A valid edge drives the count in event mode
   tmr_prescaler u_presc (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .run      (run),
      .sel      (clk_sel),
      .ext_tick (a_edge),
      .tick     (tick)
   );

   // counter control
   logic              sw_trig;
   logic              os_trig;
   logic              restart_ev;
   logic              match_a;
   logic              match_b;
   logic              clr_match;
   logic              wrap;
   logic              cap_a_pin_b;
   logic              cap_a;
   logic              cap_b;
   logic [15:0]       count_d;

   assign sw_trig    = wr_outctrl & w_data_q[`TMR_OS_SW_TRIG_BIT];
   // (R19) software or pin A edge starts the one-shot
   assign os_trig    = os_en & (sw_trig | (os_ext & a_edge));
   // (R06) restart clears after the capture
   assign restart_ev = (opmode == MODE_RESTART) & a_edge;
   assign match_a    = tick & (count_register_q == capture_compare_a_q);
   assign match_b    = tick & (count_register_q == capture_compare_b_q);
   // (R10) clear on compare match
   assign clr_match  = (opmode == MODE_CLR_MATCH) & match_a & ~cca_capture;
   // (R14) (R24) wrap from all ones, also through a match at ffff
   assign wrap       = tick & (count_register_q == 16'hffff) & ~restart_ev & ~os_trig;
   // (R02) pin B edge capture into capture_compare_a
   assign cap_a_pin_b = cca_capture & ~cca_src_a & b_edge;
   // (R05) opposite pin A edge capture into capture_compare_a
   assign cap_a      = cap_a_pin_b | (cca_capture & cca_src_a & a_opp);
   // (R01) pin A edge capture into capture_compare_b
   assign cap_b      = ccb_capture & a_edge;

   // (R25) free-running wraps, captures leave the count alone
   assign count_d = !run                    ? 16'h0000 :
                    (restart_ev | os_trig)  ? 16'h0000 :
                    !tick                   ? count_register_q :
                    clr_match               ? 16'h0000 :
                    count_register_q + 16'h0001;

   // one-shot and square wave output
   tmr_os_t           os_d;
   logic              os_hit;
   logic              out_d;

   assign os_hit = (match_a & ~cca_capture) | (match_b & ~ccb_capture);

   always_comb begin
      os_d  = os_q;
      out_d = out_q;
      unique case (os_q)
         OS_IDLE: begin
            if (os_trig) begin
               os_d  = OS_FIRST;
               out_d = 1'b0;
            end
         end
         OS_FIRST: begin
            if (os_hit) begin
               os_d  = OS_SECOND;
               out_d = 1'b1;
            end
         end
         OS_SECOND: begin
            if (os_hit) begin
               os_d  = OS_IDLE;
               out_d = 1'b0;
            end
         end
         default: begin
            os_d = OS_IDLE;
         end
      endcase
      if (!run || !os_en) begin
         os_d = OS_IDLE;
      end
      // (R16) invert every capture_compare_a plus one counts
      if (toggle_a && !os_en && match_a && !cca_capture) begin
         out_d = ~out_q;
      end
      if (!run) begin
         out_d = 1'b0;
      end
   end

   // bus channel handshakes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q     <= 1'b0;
         w_hold_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
      end else begin
         aw_hold_q     <= (aw_hold_q | aw_take) & ~wr_do;
         w_hold_q      <= (w_hold_q | w_take) & ~wr_do;
         s_axi_awready <= ~((aw_hold_q | aw_take) & ~wr_do);
         s_axi_wready  <= ~((w_hold_q | w_take) & ~wr_do);
         s_axi_bvalid  <= wr_do | (s_axi_bvalid & ~s_axi_bready);
         s_axi_rvalid  <= ar_take | (s_axi_rvalid & ~s_axi_rready);
         s_axi_arready <= ~(ar_take | (s_axi_rvalid & ~s_axi_rready));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_q   <= 8'h00;
         w_data_q    <= 32'h0000_0000;
         w_strb_q    <= 4'h0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
      end else begin
         if (aw_take) begin
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_do) begin
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (ar_take) begin
            s_axi_rdata <= rd_val;
            s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // read mux
   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (s_axi_araddr)
         `TMR_MODE_CTRL_OFS: rd_val[7:0]  = mode_control_reg_q;
         `TMR_CC_CTRL_OFS:   rd_val[7:0]  = capture_compare_ctrl_reg_q;
         `TMR_PRESCALER_OFS: rd_val[7:0]  = prescaler_mode_reg_q;
         `TMR_OUT_CTRL_OFS:  rd_val[7:0]  = output_control_reg_q;
         `TMR_CC_A_OFS:      rd_val[15:0] = capture_compare_a_q;
         `TMR_CC_B_OFS:      rd_val[15:0] = capture_compare_b_q;
         // (R15) live count readable
         `TMR_COUNT_OFS:     rd_val[15:0] = count_register_q;
         `TMR_STATUS_OFS:    rd_val[`TMR_OVF_BIT] = overflow_flag_q;
         default:            rd_val = 32'h0000_0000;
      endcase
   end

   // control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_control_reg_q         <= `TMR_CTRL_RST;
         capture_compare_ctrl_reg_q <= `TMR_CTRL_RST;
         prescaler_mode_reg_q       <= `TMR_CTRL_RST;
         output_control_reg_q       <= `TMR_CTRL_RST;
      end else begin
         if (wr_mode) begin
            mode_control_reg_q <= wr_val[7:0] & 8'h0c;
         end
         if (wr_ccctrl) begin
            capture_compare_ctrl_reg_q <= wr_val[7:0] & 8'h07;
         end
         if (wr_presc) begin
            prescaler_mode_reg_q <= wr_val[7:0] & 8'hf3;
         end
         if (wr_outctrl) begin
            output_control_reg_q <= wr_val[7:0] & 8'h1b;
         end
      end
   end

   // capture/compare registers, capture beats a software write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         capture_compare_a_q <= `TMR_CC_RST;
         capture_compare_b_q <= `TMR_CC_RST;
      end else begin
         if (cap_a) begin
            capture_compare_a_q <= count_register_q;
         end else if (wr_cca) begin
            capture_compare_a_q <= 16'(merge({16'h0000, capture_compare_a_q}, w_data_q, w_strb_q));
         end
         if (cap_b) begin
            capture_compare_b_q <= count_register_q;
         end else if (wr_ccb) begin
            capture_compare_b_q <= 16'(merge({16'h0000, capture_compare_b_q}, w_data_q, w_strb_q));
         end
      end
   end

   // counter, overflow, output, event pulses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_register_q <= 16'h0000;
         overflow_flag_q  <= 1'b0;
         ovf_hold_q       <= 1'b0;
         os_q             <= OS_IDLE;
         out_q            <= 1'b0;
         timer_output_pin <= 1'b0;
         match_a_irq      <= 1'b0;
         capture_b_irq    <= 1'b0;
      end else begin
         count_register_q <= count_d;
         // (R24) set wins, clear ignored until the next count
         overflow_flag_q  <= wrap | (overflow_flag_q & ~(wr_status & w_data_q[`TMR_OVF_BIT] & ~ovf_hold_q));
         ovf_hold_q       <= wrap | (ovf_hold_q & ~tick & run);
         os_q             <= os_d;
         out_q            <= out_d;
         timer_output_pin <= out_en & out_d;
         // (R02) (R10) match or pin B capture event
         match_a_irq      <= cap_a_pin_b | (match_a & ~cca_capture);
         // (R01) pin A capture event
         capture_b_irq    <= cap_b | (match_b & ~ccb_capture);
      end
   end
endmodule // tmr_top

// *** hw/tmr_map.svh ***
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// register byte offsets
`define TMR_MODE_CTRL_OFS   8'h00
`define TMR_CC_CTRL_OFS     8'h04
`define TMR_PRESCALER_OFS   8'h08
`define TMR_OUT_CTRL_OFS    8'h0c
`define TMR_CC_A_OFS        8'h10
`define TMR_CC_B_OFS        8'h14
`define TMR_COUNT_OFS       8'h18
`define TMR_STATUS_OFS      8'h1c

// mode_control_reg fields
`define TMR_OPMODE_LSB      2
// capture_compare_ctrl_reg fields
`define TMR_CCA_CAPTURE_BIT 0
`define TMR_CCA_SRC_A_BIT   1
`define TMR_CCB_CAPTURE_BIT 2
// prescaler_mode_reg fields
`define TMR_CLKSEL_LSB      0
`define TMR_EDGE_A_LSB      4
`define TMR_EDGE_B_LSB      6
// output_control_reg fields
`define TMR_OUT_EN_BIT      0
`define TMR_TOGGLE_A_BIT    1
`define TMR_ONESHOT_BIT     3
`define TMR_OS_EXT_BIT      4
`define TMR_OS_SW_TRIG_BIT  6
// status fields
`define TMR_OVF_BIT         0

// reset values
`define TMR_CTRL_RST        8'h00
`define TMR_CC_RST          16'h0000

// edge select codes
`define TMR_EDGE_FALL       2'b00
`define TMR_EDGE_RISE       2'b01
`define TMR_EDGE_BOTH       2'b11

// count clock select codes and divide counts
`define TMR_CLK_DIV1        2'b00
`define TMR_CLK_DIV4        2'b01
`define TMR_CLK_DIV16       2'b10
`define TMR_CLK_PIN_A       2'b11
`define TMR_DIV4_LAST       4'h3
`define TMR_DIV16_LAST      4'hf

`endif

// *** hw/tmr_pkg.sv ***
package tmr_pkg;

   typedef enum logic [1:0] {
      MODE_STOP      = 2'b00,
      MODE_RESTART   = 2'b01,
      MODE_FREE      = 2'b10,
      MODE_CLR_MATCH = 2'b11
   } tmr_mode_t;

   typedef enum logic [1:0] {
      OS_IDLE   = 2'b00,
      OS_FIRST  = 2'b01,
      OS_SECOND = 2'b10
   } tmr_os_t;

   typedef enum logic [1:0] {
      RESP_OKAY   = 2'b00,
      RESP_SLVERR = 2'b10
   } tmr_resp_t;

endpackage

// *** hw/tmr_prescaler.sv ***
`timescale 1ns/1ps
`include "tmr_map.svh"

module tmr_prescaler (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       run,
   input  wire logic [1:0] sel,
   input  wire logic       ext_tick,
   output logic            tick
);
   import tmr_pkg::*;

   logic [3:0] div_q;

   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         div_q <= 4'h0;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end

   // (R21) count clock choice
   assign tick = run & ((sel == `TMR_CLK_DIV1)  ? 1'b1 :
                        (sel == `TMR_CLK_DIV4)  ? (div_q[1:0] == `TMR_DIV4_LAST) :
                        (sel == `TMR_CLK_DIV16) ? (div_q == `TMR_DIV16_LAST) :
                        ext_tick);
endmodule // tmr_prescaler

// *** hw/tmr_edge_filter.sv ***
`timescale 1ns/1ps
`include "tmr_map.svh"

module tmr_edge_filter (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       sample,
   input  wire logic       pin,
   input  wire logic [1:0] edge_sel,
   output logic            valid_edge,
   output logic            opp_edge
);
   import tmr_pkg::*;

   logic s1_q;
   logic s2_q;
   logic lev_q;
   logic rise;
   logic fall;

   // two equal samples needed before the level is accepted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q  <= 1'b0;
         s2_q  <= 1'b0;
         lev_q <= 1'b0;
      end else if (sample) begin
         s1_q <= pin;
         s2_q <= s1_q;
         if (s1_q == s2_q) begin
            lev_q <= s2_q;
         end
      end
   end

   assign rise = sample & s1_q & s2_q & ~lev_q;
   assign fall = sample & ~s1_q & ~s2_q & lev_q;

   assign valid_edge = (edge_sel == `TMR_EDGE_RISE) ? rise :
                       (edge_sel == `TMR_EDGE_FALL) ? fall :
                       (edge_sel == `TMR_EDGE_BOTH) ? (rise | fall) : 1'b0;
   assign opp_edge   = (edge_sel == `TMR_EDGE_RISE) ? fall :
                       (edge_sel == `TMR_EDGE_FALL) ? rise : 1'b0;
endmodule // tmr_edge_filter

// *** verif/tmr_top_asserts.sv ***
`timescale 1ns/1ps
module tmr_top_asserts (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic input_pin_a,
   input wire logic timer_output_pin,
   input wire logic match_a_irq,
   input wire logic capture_b_irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_irqb_pulse: assert property (capture_b_irq |=> !capture_b_irq)
      else $error("capture_b_irq longer than one cycle");
   chk_irqa_pulse: assert property (match_a_irq |=> !match_a_irq)
      else $error("match_a_irq longer than one cycle");
   chk_filter_a: assert property (capture_b_irq |-> $past(input_pin_a, 2) == $past(input_pin_a, 3))
      else $error("capture without two equal pin samples");
   chk_start_quiet: assert property ($rose(aresetn) |-> !timer_output_pin && !match_a_irq && !capture_b_irq)
      else $error("outputs active while counter stopped");
   chk_sq_match: assert property ($rose(timer_output_pin) |-> match_a_irq || capture_b_irq ||
      $past(match_a_irq))
      else $error("output rose without a compare match");
   chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
endmodule // tmr_top_asserts

// *** verif/tmr_pulse_src.sv ***
`timescale 1ns/1ps
module tmr_pulse_src (
   input wire logic aclk,
   output logic     pin_a,
   output logic     pin_b
);
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
   end
   // new pin levels just after an edge
   task automatic drive(input logic a, input logic b);
      @(posedge aclk);
      pin_a <= a;
      pin_b <= b;
   endtask
   // one-cycle spike, too short for the input filter
   task automatic spike();
      @(posedge aclk);
      pin_a <= ~pin_a;
      @(posedge aclk);
      pin_a <= ~pin_a;
   endtask
endmodule // tmr_pulse_src

// *** verif/tb_timer_capture_event_square_modes.sv ***
`timescale 1ns/1ps
`include "tmr_map.svh"
module tb_timer_capture_event_square_modes;
   import tmr_pkg::*;
   logic        aclk = 1'b0;
   logic        aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, input_pin_a, input_pin_b;
   logic        timer_output_pin, match_a_irq, capture_b_irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, v, u;
   tmr_resp_t   s_axi_bresp, s_axi_rresp;
   logic [67:0] exp_q[$], me;
   logic [1:0]  ec[3] = '{2'b01, 2'b00, 2'b11};
   int          errors = 0, checks = 0, na = 0, nb = 0, w, t, a0, b0;
   time         t0;

   tmr_top dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
      .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready(1'b1), .s_axi_rdata,
      .s_axi_rresp, .input_pin_a, .input_pin_b, .timer_output_pin, .match_a_irq, .capture_b_irq);
   tmr_pulse_src src (.aclk, .pin_a(input_pin_a), .pin_b(input_pin_b));

   always #50 aclk = ~aclk;

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      chk(34'(s_axi_bresp), '0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] m, input logic [33:0] e, output logic [31:0] d);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      exp_q.push_back({m, e});
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
   endtask

   task automatic rx(input logic [7:0] a, input logic [33:0] e);
      logic [31:0] d;
      rd(a, '1, e, d);
   endtask

   // read answers against the oldest note, irq pulses counted
   always @(posedge aclk) begin
      if (s_axi_rvalid === 1'b1 && exp_q.size() > 0) begin
         me = exp_q.pop_front();
         chk({s_axi_rresp, s_axi_rdata} & me[67:34], me[33:0]);
      end
      if (match_a_irq === 1'b1) na++;
      if (capture_b_irq === 1'b1) nb++;
   end

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #9_000_000;
      errors++;
      tally_and_finish();
   end

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      void'($urandom(25));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      wr(`TMR_COUNT_OFS, 32'h1234);
      for (int i = 0; i < 8; i++) rx(8'(4 * i), '0);
      rx(8'h20, {RESP_SLVERR, 32'h0});
      $display("test reset values done");
      wr(`TMR_PRESCALER_OFS, 32'hf0);
      wr(`TMR_CC_CTRL_OFS, 32'h5);
      wr(`TMR_MODE_CTRL_OFS, 32'h8);
      src.spike();
      for (int l = 1; l >= 0; l--) begin
         w = 10 + $urandom % 20;
         src.drive(l[0], !l[0]);
         repeat (w - 1) @(posedge aclk);
         src.drive(l[0], l[0]);
         repeat (8) @(posedge aclk);
         rd(`TMR_CC_B_OFS, 34'h3_0000_0000, '0, v);
         rd(`TMR_CC_A_OFS, 34'h3_0000_0000, '0, u);
         chk(34'(16'(u - v)), 34'(w));
      end
      chk(34'(nb), 34'd2);
      chk(34'(na), 34'd2);
      wr(`TMR_MODE_CTRL_OFS, 32'h0);
      wr(`TMR_PRESCALER_OFS, 32'h10);
      wr(`TMR_CC_CTRL_OFS, 32'h7);
      wr(`TMR_MODE_CTRL_OFS, 32'h4);
      repeat (2) begin
         src.drive(1'b1, 1'b0);
         repeat (w - 1) @(posedge aclk);
         src.drive(1'b0, 1'b0);
         repeat (w - 1) @(posedge aclk);
      end
      rx(`TMR_CC_A_OFS, 34'(w - 1));
      rx(`TMR_CC_B_OFS, 34'(2 * w - 1));
      $display("test capture done");
      foreach (ec[k]) begin
         wr(`TMR_MODE_CTRL_OFS, 32'h0);
         wr(`TMR_PRESCALER_OFS, 32'({ec[k], 4'h3}));
         wr(`TMR_CC_CTRL_OFS, 32'h0);
         wr(`TMR_CC_A_OFS, 32'h3);
         wr(`TMR_MODE_CTRL_OFS, 32'hc);
         a0 = na;
         repeat (5) begin
            src.drive(1'b1, 1'b0);
            repeat (3) @(posedge aclk);
            src.drive(1'b0, 1'b0);
            repeat (3) @(posedge aclk);
         end
         src.spike();
         repeat (4) @(posedge aclk);
         t = (ec[k] == 2'b11) ? 10 : 5;
         rx(`TMR_COUNT_OFS, 34'(t % 4));
         rx(`TMR_STATUS_OFS, '0);
         chk(34'(na - a0), 34'(t / 4));
      end
      $display("test event counter done");
      for (int s = 0; s < 3; s++) begin
         wr(`TMR_MODE_CTRL_OFS, 32'h0);
         // clock, capture control, output control, compare, mode
         wr(`TMR_PRESCALER_OFS, 32'(s));
         wr(`TMR_CC_CTRL_OFS, 32'h0);
         wr(`TMR_OUT_CTRL_OFS, 32'h3);
         wr(`TMR_CC_A_OFS, 32'h4);
         wr(`TMR_MODE_CTRL_OFS, 32'hc);
         @(timer_output_pin);
         @(timer_output_pin);
         t0 = $time;
         @(timer_output_pin);
         chk(34'(($time - t0) / 100), 34'(5 << (2 * s)));
      end
      $display("test square wave done");
      wr(`TMR_MODE_CTRL_OFS, 32'h0);
      wr(`TMR_PRESCALER_OFS, 32'h0);
      wr(`TMR_OUT_CTRL_OFS, 32'h9);
      wr(`TMR_CC_B_OFS, 32'h2);
      wr(`TMR_MODE_CTRL_OFS, 32'h8);
      wr(`TMR_OUT_CTRL_OFS, 32'h49);
      @(posedge timer_output_pin) t0 = $time;
      @(negedge timer_output_pin);
      chk(34'(($time - t0) / 100), 34'd2);
      repeat (65540) @(posedge aclk);
      rx(`TMR_STATUS_OFS, 34'h1);
      wr(`TMR_STATUS_OFS, 32'h1);
      rx(`TMR_STATUS_OFS, '0);
      $display("test one-shot done");
      tally_and_finish();
   end
endmodule // tb_timer_capture_event_square_modes

bind tmr_top tmr_top_asserts chk_i (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_bvalid, .s_axi_bready, .input_pin_a, .timer_output_pin, .match_a_irq, .capture_b_irq);
